//--- tb/cfcc_host.sv
// Purpose: Host model that sends framed commands and takes replies
// Assumes: One character offered at a time, held until taken
// Notes: reply holds the latest reply, done pulses after its CR
`timescale 1ns/1ps
`include "cfcc_cfg.svh"
module cfcc_host (
  input wire logic clk,
  input wire logic stall,
  input wire logic rx_ready,
  input wire cfcc_pkg::cfcc_char_t tx_data,
  input wire logic tx_valid,
  output cfcc_pkg::cfcc_char_t rx_data,
  output logic rx_valid,
  output logic rx_err,
  output logic tx_ready,
  output logic done,
  output logic [127:0] reply
);
  import cfcc_pkg::*;
  logic fresh = 1'b1;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_err = 1'b0;
    tx_ready = 1'b0;
    done = 1'b0;
    reply = 128'h0;
  end
  // Idle line shows the inverse of the last character
  task automatic send(input string s, input logic err);
    for (int i = 0; i <= s.len(); i++) begin
      rx_data <= (i == s.len()) ? `CFCC_CH_CR : cfcc_char_t'(s[i]);
      rx_valid <= 1'b1;
      rx_err <= err && i == 1;
      do @(posedge clk); while (!rx_ready);
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      rx_data <= ~rx_data;
      @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    tx_ready <= !stall;
    done <= tx_valid && tx_ready && tx_data == `CFCC_CH_CR;
    if (tx_valid && tx_ready) begin
      reply <= {(fresh ? 120'h0 : reply[119:0]), tx_data};
      fresh <= tx_data == `CFCC_CH_CR;
    end
  end
endmodule // cfcc_host

//--- tb/cfcc_top_sva.sv
// Purpose: Checks on the serial reply stream of the command handler
// Assumes: Checksum disabled, so a reject reply is lead, address, CR
// Notes: Bound to cfcc_top
`timescale 1ns/1ps
`include "cfcc_cfg.svh"
module cfcc_top_sva (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire cfcc_pkg::cfcc_char_t RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_ERR,
  input wire logic RX_READY,
  input wire cfcc_pkg::cfcc_char_t TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY
);
  import cfcc_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  logic [3:0] beat_r;
  logic nak_r;
  logic tx_hs;
  logic tx_end;
  logic rx_end;
  assign tx_hs = TX_VALID && TX_READY;
  assign tx_end = tx_hs && TX_DATA == `CFCC_CH_CR;
  assign rx_end = RX_VALID && RX_READY && RX_DATA == `CFCC_CH_CR && !RX_ERR;
  // Beats since the lead character, and whether it was a reject
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      beat_r <= 4'd0;
      nak_r <= 1'b0;
    end else if (tx_hs) begin
      beat_r <= tx_end ? 4'd0 : beat_r + 4'd1;
      nak_r <= (beat_r == 4'd0) ? TX_DATA == `CFCC_CH_NAK : nak_r;
    end
  end
  reply_lead_a: assert property ($rose(TX_VALID) |->
    TX_DATA inside {`CFCC_CH_ACK, `CFCC_CH_NAK})
    else $error("bad reply lead");
  reply_hold_a: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA)) else $error("reply char not held");
  reply_addr_a: assert property (tx_hs &&
    TX_DATA inside {`CFCC_CH_ACK, `CFCC_CH_NAK} |=> TX_VALID &&
    TX_DATA inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("no address after lead");
  reply_gap_a: assert property (tx_end |=> !TX_VALID [*4])
    else $error("reply continues after its terminator");
  nak_len_a: assert property (tx_end && nak_r |-> beat_r == 4'd3)
    else $error("reject reply too long");
  reply_cause_a: assert property ($rose(TX_VALID) |->
    $past(rx_end, 2))
    else $error("reply without clean end");
  err_silent_a: assert property (RX_VALID && RX_READY && RX_ERR |=>
    !TX_VALID [*3]) else $error("reply after a communication error");
  rx_block_a: assert property (TX_VALID |-> !RX_READY)
    else $error("receiver open while replying");
endmodule // cfcc_top_sva
bind cfcc_top cfcc_top_sva u_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_ERR(RX_ERR),
  .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY));

//--- tb/tb_counter_freq_config_commands.sv
// Purpose: Self-checking bench of the command handler
// Assumes: Starts with checksum off, module address 01, all channels up counters; the scenarios then change each
// Notes: Replies and bus reads are compared in arrival order
`timescale 1ns/1ps
`include "cfcc_cfg.svh"
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); \
  end \
end
module tb_counter_freq_config_commands;
  import cfcc_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, RX_VALID, RX_ERR, RX_READY, TX_VALID, TX_READY;
  cfcc_char_t RX_DATA, TX_DATA;
  logic [7:0] PULSE_IN = 8'h00;
  logic [7:0] FREQ_ZERO;
  logic done;
  logic rd_dp = 1'b0;
  logic [127:0] reply;
  logic [31:0] rnd = 32'd69900;
  logic [127:0] expq[$];
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  cfcc_top #(.TICK_CYCLES(20)) DUT (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(`CFCC_HSIZE_WORD), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
    .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_ERR(RX_ERR),
    .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .PULSE_IN(PULSE_IN), .FREQ_ZERO(FREQ_ZERO));
  cfcc_host u_host (.clk(CLK_SYS), .stall(rnd[9]), .rx_ready(RX_READY),
    .tx_data(TX_DATA), .tx_valid(TX_VALID), .rx_data(RX_DATA),
    .rx_valid(RX_VALID), .rx_err(RX_ERR), .tx_ready(TX_READY),
    .done(done), .reply(reply));
  initial forever #25 CLK_SYS = ~CLK_SYS;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic string hx(input logic [31:0] v, input int n);
    string d = "0123456789ABCDEF";
    string s = "";
    for (int i = n - 1; i >= 0; i--) s = {s, d.substr(v[4*i+:4], v[4*i+:4])};
    return s;
  endfunction
  function automatic logic [127:0] fr(input string s);
    logic [127:0] v = 128'h0;
    for (int i = 0; i < s.len(); i++) v = {v[119:0], s[i]};
    return {v[119:0], `CFCC_CH_CR};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic take(input logic [127:0] got);
    logic [127:0] e;
    e = (expq.size() > 0) ? expq.pop_front() : 128'h0;
    `CHK(got, e)
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, d);
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    do @(posedge CLK_SYS); while (!HREADYOUT);
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_dp <= !wr;
    if (!wr) expq.push_back({96'h0, d});
    do @(posedge CLK_SYS); while (!HREADYOUT);
    rd_dp <= 1'b0;
  endtask
  task automatic cmd(input string s, input string r, input logic err = 0);
    if (r.len() > 0) expq.push_back(fr(r));
    u_host.send(s, err);
    for (int k = 0; k < 400 && expq.size() > 0; k++) @(posedge CLK_SYS);
    repeat (4) @(posedge CLK_SYS);
  endtask
  always @(posedge CLK_SYS) begin
    rnd <= lfsr(rnd);
    PULSE_IN[7:4] <= rnd[7:4];
    cyc <= cyc + 1;
    if (done) take(reply);
    if (rd_dp) take({96'h0, HRDATA});
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ---------
  // Scenarios
  // ---------
  initial begin
    logic [31:0] v;
    repeat (5) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    ahb(0, `CFCC_OFS_CTRL, 32'h1);
    for (int c = 0; c < 8; c += 7) begin
      v = rnd;
      cmd({"@01P", hx(c, 1), hx(v, 8)}, "!01");
      cmd({"@01G", hx(c, 1)}, {"!01", hx(v, 8)});
    end
    cmd("@01P2F0000000", "!01");
    ahb(0, `CFCC_OFS_PRESET + 8, 32'hf0000000);
    $display("test preset done");
    cmd("@01SC3A", "!01");
    cmd("@01SC", "!013A");
    cmd("@01SC00", "!01");
    cmd("@01SC", "!0100");
    cmd("@01FA3A", "?01");
    cmd("@01FH01", "?01");
    cmd("@01FT", "?01");
    $display("test type gate done");
    ahb(1, `CFCC_OFS_TYPE_LO, 32'h50505151);
    ahb(0, `CFCC_OFS_TYPE_LO, 32'h50505151);
    cmd("@01FA03", "!01");
    cmd("@01FH02", "!01");
    cmd("@01FH", "!0102");
    cmd("@01FH04", "?01");
    cmd("@01FT", "!010A");
    cmd("@01FTFF", "!01");
    cmd("@01FT", "!01FF");
    ahb(1, `CFCC_OFS_MODES, 32'h0);
    ahb(0, `CFCC_OFS_MODES, 32'hff000203);
    ahb(0, 32'h80, 32'h0);
    cmd("@01G0", "?01");
    cmd("@01SC01", "?01");
    $display("test freq modes done");
    cmd("@02FH", "");
    cmd("@01FH", "", 1'b1);
    cmd("@01fh", "");
    v = rnd | 32'h80;
    ahb(1, `CFCC_OFS_CTRL, {24'h0, v[7:0]});
    cmd({"@", hx(v, 2), "FT"}, {"!", hx(v, 2), "FF"});
    cmd("@01FT", "");
    ahb(1, `CFCC_OFS_CTRL, 32'h101);
    $display("test silence done");
    cmd("@01FT029D", "!0182");
    ahb(1, `CFCC_OFS_CTRL, 32'h1);
    PULSE_IN[0] <= 1'b1;
    repeat (12) @(posedge CLK_SYS);
    `CHK(FREQ_ZERO[0], 1'b0)
    repeat (100) @(posedge CLK_SYS);
    `CHK(FREQ_ZERO[0], 1'b1)
    PULSE_IN[0] <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    PULSE_IN[0] <= 1'b1;
    repeat (10) @(posedge CLK_SYS);
    `CHK(FREQ_ZERO[0], 1'b0)
    $display("test timeout done");
    cmd("@01SC04", "!01");
    cmd("@01P2FFFFFFFE", "!01");
    cmd("@01P3FFFFFFFF", "!01");
    repeat (3) begin
      PULSE_IN[3:2] <= 2'b11;
      repeat (6) @(posedge CLK_SYS);
      PULSE_IN[3:2] <= 2'b00;
      repeat (6) @(posedge CLK_SYS);
    end
    ahb(0, `CFCC_OFS_COUNT + 8, 32'hffffffff);
    ahb(0, `CFCC_OFS_COUNT + 12, 32'h00000002);
    repeat (2) @(posedge CLK_SYS);
    $display("test overflow done");
    `CHK(expq.size(), 0)
    report_and_stop();
  end
endmodule // tb_counter_freq_config_commands

//--- verilog/cfcc_cfg.svh
// Purpose: Shared constants of the counter and frequency command handler
// Assumes: Included by every design file except the channel interface
// Notes: Characters are ASCII codes
`ifndef CFCC_CFG_SVH
`define CFCC_CFG_SVH
`define CFCC_NCH 8
`define CFCC_BUF_LEN 16
`define CFCC_CLK_NS 50
`define CFCC_TENTH_NS 100000000
`define CFCC_TICK_W 24
`define CFCC_CH_AT 8'h40
`define CFCC_CH_CR 8'h0d
`define CFCC_CH_ACK 8'h21
`define CFCC_CH_NAK 8'h3f
`define CFCC_CH_0 8'h30
`define CFCC_CH_7 8'h37
`define CFCC_CH_9 8'h39
`define CFCC_CH_A 8'h41
`define CFCC_CH_C 8'h43
`define CFCC_CH_F 8'h46
`define CFCC_CH_G 8'h47
`define CFCC_CH_H 8'h48
`define CFCC_CH_P 8'h50
`define CFCC_CH_S 8'h53
`define CFCC_CH_T 8'h54
`define CFCC_HEX_TEN 4'ha
`define CFCC_HEX_ADJ 4'h9
`define CFCC_TYPE_UP 8'h50
`define CFCC_TYPE_FREQ 8'h51
`define CFCC_OFS_CTRL 8'h00
`define CFCC_OFS_TYPE_LO 8'h04
`define CFCC_OFS_TYPE_HI 8'h08
`define CFCC_OFS_MODES 8'h0c
`define CFCC_OFS_STATUS 8'h10
`define CFCC_OFS_COUNT 8'h20
`define CFCC_OFS_PRESET 8'h40
`define CFCC_REGION 8'he0
`define CFCC_CTRL_CHK 8
`define CFCC_RST_ADDR 8'h01
`define CFCC_RST_TYPE 32'h50505050
`define CFCC_RST_TIMEOUT 8'h0a
`define CFCC_HSIZE_WORD 3'h2
`define CFCC_CNT_MAX 32'hffffffff
`define CFCC_IDLE_MAX 8'hff
`define CFCC_LEN_SHORT 5'd4
`define CFCC_LEN_MASK 5'd6
`define CFCC_LEN_PRESET 5'd12
`define CFCC_LEN_ADDR 5'd2
`define CFCC_ND_MASK 4'd2
`define CFCC_ND_WORD 4'd8
`define CFCC_RP_HDR 5'd3
`endif

//--- verilog/cfcc_chan.sv
// Purpose: One input channel: up counter and no-pulse timeout watch
// Assumes: pulse_edge is already synchronised, tick is one tenth second
// Notes: Load from preset wins over a counted edge
`timescale 1ns/1ps
`include "cfcc_cfg.svh"
module cfcc_chan (
  input wire logic clk,
  input wire logic rst_n,
  cfcc_chan_if.chan ch
);
  import cfcc_pkg::*;

  logic [31:0] count_r;
  logic [7:0] idle_r;
  logic zero_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (ch.load) begin
      count_r <= ch.preset;
    end else if (ch.pulse_edge) begin
      if (count_r == `CFCC_CNT_MAX && ch.stop_ovf) begin
        count_r <= `CFCC_CNT_MAX;
      end else begin
        count_r <= count_r + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timeout watch
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= '0;
    end else if (ch.pulse_edge) begin
      idle_r <= '0;
    end else if (ch.tick && idle_r != `CFCC_IDLE_MAX) begin
      idle_r <= idle_r + 8'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_r <= 1'b0;
    end else begin
      zero_r <= !ch.pulse_edge && ch.timeout != 8'h0 &&
                idle_r >= ch.timeout;
    end
  end

  assign ch.count = count_r;
  assign ch.freq_zero = zero_r;
endmodule // cfcc_chan

//--- verilog/cfcc_chan_if.sv
// Purpose: Bundle between the command handler and one channel
// Assumes: Same clock on both sides
// Notes: Controls flow to the channel, results flow back
`timescale 1ns/1ps
interface cfcc_chan_if;
  logic pulse_edge;
  logic tick;
  logic stop_ovf;
  logic load;
  logic [7:0] timeout;
  logic [31:0] preset;
  logic [31:0] count;
  logic freq_zero;
  modport top(output pulse_edge, tick, stop_ovf, load, timeout, preset,
              input count, freq_zero);
  modport chan(input pulse_edge, tick, stop_ovf, load, timeout, preset,
               output count, freq_zero);
endinterface

//--- verilog/cfcc_pkg.sv
// Purpose: Types and character helpers of the command handler
// Assumes: cfcc_cfg.svh supplies the constants
// Notes: Hex digits are upper case only
`include "cfcc_cfg.svh"
package cfcc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RECV = 4'b0010,
    ST_PARSE = 4'b0100,
    ST_SEND = 4'b1000
  } cfcc_state_t;
  typedef logic [7:0] cfcc_char_t;

  function automatic logic is_hex(input cfcc_char_t c);
    return (c >= `CFCC_CH_0 && c <= `CFCC_CH_9) ||
           (c >= `CFCC_CH_A && c <= `CFCC_CH_F);
  endfunction

  function automatic logic [3:0] hex_val(input cfcc_char_t c);
    if (c <= `CFCC_CH_9) begin
      return c[3:0];
    end
    return c[3:0] + `CFCC_HEX_ADJ;
  endfunction

  function automatic cfcc_char_t hex_chr(input logic [3:0] n);
    if (n < `CFCC_HEX_TEN) begin
      return `CFCC_CH_0 + {4'h0, n};
    end
    return `CFCC_CH_A + {4'h0, n} - {4'h0, `CFCC_HEX_TEN};
  endfunction
endpackage

//--- verilog/cfcc_top.sv
// Purpose: Framed ASCII command handler for counter and frequency setup
// Assumes: RX and TX bytes come from a UART on CLK_SYS
// Notes: Registers over AHB-Lite, zero wait states
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cfcc_cfg.svh"
// Functional notes
// - Frames start with @, two hex address digits, command, checksum, CR.
// - Replies start ! or ?, then own address, checksum, CR.
// - Auto frequency set: mask bit 1 enables, 0 disables, bit 0 channel 0.
// - Auto, high frequency and timeout commands only for type 51 channels.
// - High frequency read returns two-digit mask of enabled channels.
// - High frequency set enables or disables per mask bit, then acknowledges.
// - Timeout read returns two hex digits in tenths of a second.
// - Timeout set stores module-wide timeout in tenths, then acknowledges.
// - No pulse for the whole timeout forces channel frequency to zero.
// - Preset read of channel 0 to 7 returns eight hex digits.
// - Preset write stores 32-bit value for the channel and acknowledges.
// - Preset read and write only for up counter channels, type 50.
// - Overflow stop read returns two-digit mask of enabled channels.
// - Overflow stop set enables or disables per mask bit.
// - Overflow stop commands only for type 50 channels.
// - Accepted overflow stop set replies with acknowledge and address only.
// - Silent on bad syntax, communication error or foreign address.
module cfcc_top #(
  parameter int unsigned TICK_CYCLES = `CFCC_TENTH_NS / `CFCC_CLK_NS
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire cfcc_pkg::cfcc_char_t RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_ERR,
  output logic RX_READY,
  output cfcc_pkg::cfcc_char_t TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  input wire logic [7:0] PULSE_IN,
  output logic [7:0] FREQ_ZERO
);
  import cfcc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_r, rst_n;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cfcc_state_t state_r;
  cfcc_char_t buf_r [0:`CFCC_BUF_LEN-1];
  cfcc_char_t tx_r [0:`CFCC_BUF_LEN-1];
  cfcc_char_t rp [0:`CFCC_BUF_LEN-1];
  logic [4:0] len_r, tx_cnt_r, m, rp_len;
  logic bad_r, chk_en_r, sum_ok;
  logic [7:0] sum_r, s1_r, s2_r, own_r, csum;
  logic [31:0] type_lo_r, type_hi_r;
  wire [63:0] type_all = {type_hi_r, type_lo_r};
  logic [7:0] auto_r, high_r, ovf_r, tmo_r, freq_ch, up_ch;
  logic [31:0] preset_r [0:`CFCC_NCH-1];
  logic [7:0] load_r;
  logic p_silent, p_ack, p_wr_auto, p_wr_high, p_wr_tmo, p_wr_ovf, p_wr_pre;
  logic [3:0] p_nd;
  logic [31:0] p_data, p_val;
  logic [7:0] p_mask, vv, elig, cur;
  logic [2:0] p_ch;
  logic vv_ok, is_rd, is_set, word_ok;
  cfcc_char_t c1, c2;
  logic [`CFCC_TICK_W-1:0] tick_cnt_r;
  logic tick;
  logic [7:0] ps1_r, ps2_r, ps3_r, plvl_r, pedge;
  logic [7:0] fz;
  logic [31:0] cnt [0:`CFCC_NCH-1];

  // ----------------------------------------------------------------
  // Channel types
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `CFCC_NCH; i++) begin
      freq_ch[i] = type_all[8*i +: 8] == `CFCC_TYPE_FREQ;
      up_ch[i] = type_all[8*i +: 8] == `CFCC_TYPE_UP;
    end
  end

  // ----------------------------------------------------------------
  // Frame receive
  // ----------------------------------------------------------------
  assign RX_READY = state_r == ST_IDLE || state_r == ST_RECV;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (RX_VALID && RX_DATA == `CFCC_CH_AT) begin
          state_r <= ST_RECV;
        end
        ST_RECV: if (RX_VALID && RX_DATA == `CFCC_CH_CR) begin
          state_r <= ST_PARSE;
        end
        ST_PARSE: state_r <= p_silent ? ST_IDLE : ST_SEND;
        ST_SEND: if (TX_READY && tx_cnt_r == 5'd1) begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      len_r <= '0;
      bad_r <= 1'b0;
      sum_r <= '0;
      s1_r <= '0;
      s2_r <= '0;
      for (int i = 0; i < `CFCC_BUF_LEN; i++) begin
        buf_r[i] <= '0;
      end
    end else if (RX_VALID && RX_READY) begin
      if (RX_DATA == `CFCC_CH_AT) begin
        len_r <= '0;
        bad_r <= RX_ERR;
        sum_r <= RX_DATA;
        s1_r <= '0;
        s2_r <= '0;
      end else if (state_r == ST_RECV && RX_DATA != `CFCC_CH_CR) begin
        s2_r <= s1_r;
        s1_r <= sum_r;
        sum_r <= sum_r + RX_DATA;
        if (len_r == 5'(`CFCC_BUF_LEN) || RX_ERR) begin
          bad_r <= 1'b1;
        end else begin
          buf_r[len_r[3:0]] <= RX_DATA;
          len_r <= len_r + 5'd1;
        end
      end else if (RX_ERR) begin
        bad_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    p_silent = 1'b1;
    p_ack = 1'b0;
    p_nd = '0;
    p_data = '0;
    p_val = '0;
    p_mask = '0;
    p_ch = '0;
    {p_wr_auto, p_wr_high, p_wr_tmo, p_wr_ovf, p_wr_pre} = '0;
    m = chk_en_r ? len_r - `CFCC_LEN_ADDR : len_r;
    sum_ok = !chk_en_r || (len_r >= `CFCC_LEN_ADDR &&
      is_hex(buf_r[len_r[3:0] - 4'd2]) && is_hex(buf_r[len_r[3:0] - 4'd1]) &&
      {hex_val(buf_r[len_r[3:0] - 4'd2]),
       hex_val(buf_r[len_r[3:0] - 4'd1])} == s2_r);
    c1 = buf_r[2];
    c2 = buf_r[3];
    vv = {hex_val(buf_r[4]), hex_val(buf_r[5])};
    vv_ok = is_hex(buf_r[4]) && is_hex(buf_r[5]);
    word_ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      word_ok = word_ok && is_hex(buf_r[4+i]);
      p_val = {p_val[27:0], hex_val(buf_r[4+i])};
    end
    elig = (c1 == `CFCC_CH_S) ? up_ch : freq_ch;
    cur = (c2 == `CFCC_CH_H) ? high_r : (c2 == `CFCC_CH_T) ? tmo_r :
          (c2 == `CFCC_CH_C) ? ovf_r : auto_r;
    is_rd = m == `CFCC_LEN_SHORT && c2 != `CFCC_CH_A;
    is_set = m == `CFCC_LEN_MASK && vv_ok;
    p_ch = c2[2:0];
    if (!bad_r && sum_ok && m >= `CFCC_LEN_ADDR && is_hex(buf_r[0]) &&
        is_hex(buf_r[1]) &&
        {hex_val(buf_r[0]), hex_val(buf_r[1])} == own_r) begin
      if ((c1 == `CFCC_CH_F && (c2 == `CFCC_CH_A || c2 == `CFCC_CH_H ||
           c2 == `CFCC_CH_T)) || (c1 == `CFCC_CH_S && c2 == `CFCC_CH_C)) begin
        p_silent = !(is_rd || is_set);
        p_ack = elig != 8'h0 && (is_rd || c2 == `CFCC_CH_T ||
                (vv & ~elig) == 8'h0);
        if (is_rd && p_ack) begin
          p_nd = `CFCC_ND_MASK;
          p_data[31:24] = (c2 == `CFCC_CH_T) ? tmo_r : (cur & elig);
        end
        p_mask = (c2 == `CFCC_CH_T) ? vv : ((cur & ~elig) | vv);
        if (is_set && p_ack) begin
          p_wr_auto = c2 == `CFCC_CH_A;
          p_wr_high = c2 == `CFCC_CH_H;
          p_wr_tmo = c2 == `CFCC_CH_T;
          p_wr_ovf = c2 == `CFCC_CH_C;
        end
      end else if (c1 == `CFCC_CH_G && m == `CFCC_LEN_SHORT &&
                   c2 >= `CFCC_CH_0 && c2 <= `CFCC_CH_7) begin
        p_silent = 1'b0;
        p_ack = up_ch[p_ch];
        if (p_ack) begin
          p_nd = `CFCC_ND_WORD;
          p_data = preset_r[p_ch];
        end
      end else if (c1 == `CFCC_CH_P && m == `CFCC_LEN_PRESET && word_ok &&
                   c2 >= `CFCC_CH_0 && c2 <= `CFCC_CH_7) begin
        p_silent = 1'b0;
        p_ack = up_ch[p_ch];
        p_wr_pre = p_ack;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply build
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `CFCC_BUF_LEN; i++) begin
      rp[i] = '0;
    end
    rp[0] = p_ack ? `CFCC_CH_ACK : `CFCC_CH_NAK;
    rp[1] = hex_chr(own_r[7:4]);
    rp[2] = hex_chr(own_r[3:0]);
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < p_nd) begin
        rp[3+i] = hex_chr(p_data[31-4*i -: 4]);
      end
    end
    rp_len = `CFCC_RP_HDR + {1'b0, p_nd};
    csum = '0;
    for (int i = 0; i < 11; i++) begin
      if (5'(i) < rp_len) begin
        csum = csum + rp[i];
      end
    end
    if (chk_en_r) begin
      rp[rp_len[3:0]] = hex_chr(csum[7:4]);
      rp[rp_len[3:0] + 4'd1] = hex_chr(csum[3:0]);
      rp_len = rp_len + 5'd2;
    end
    rp[rp_len[3:0]] = `CFCC_CH_CR;
    rp_len = rp_len + 5'd1;
  end

  // ----------------------------------------------------------------
  // Reply send
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_r <= '0;
      for (int i = 0; i < `CFCC_BUF_LEN; i++) begin
        tx_r[i] <= '0;
      end
    end else if (state_r == ST_PARSE && !p_silent) begin
      tx_r <= rp;
      tx_cnt_r <= rp_len;
    end else if (state_r == ST_SEND && TX_READY) begin
      for (int i = 0; i < `CFCC_BUF_LEN - 1; i++) begin
        tx_r[i] <= tx_r[i+1];
      end
      tx_cnt_r <= tx_cnt_r - 5'd1;
    end
  end

  assign TX_DATA = tx_r[0];
  assign TX_VALID = state_r == ST_SEND;

  // ----------------------------------------------------------------
  // Mode settings
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      auto_r <= '0;
      high_r <= '0;
      ovf_r <= '0;
      tmo_r <= `CFCC_RST_TIMEOUT;
      load_r <= '0;
      for (int i = 0; i < `CFCC_NCH; i++) begin
        preset_r[i] <= '0;
      end
    end else begin
      load_r <= '0;
      if (state_r == ST_PARSE) begin
        if (p_wr_auto) auto_r <= p_mask;
        if (p_wr_high) high_r <= p_mask;
        if (p_wr_tmo) tmo_r <= p_mask;
        if (p_wr_ovf) ovf_r <= p_mask;
        if (p_wr_pre) begin
          preset_r[p_ch] <= p_val;
          load_r[p_ch] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pulse inputs and tenth-second tick
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      {ps1_r, ps2_r, ps3_r, plvl_r} <= '0;
    end else begin
      ps1_r <= PULSE_IN;
      ps2_r <= ps1_r;
      ps3_r <= ps2_r;
      plvl_r <= (ps2_r & ps3_r) | (plvl_r & (ps2_r | ps3_r));
    end
  end
  assign pedge = ps2_r & ps3_r & ~plvl_r;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + `CFCC_TICK_W'(1);
    end
  end
  assign tick = tick_cnt_r == `CFCC_TICK_W'(TICK_CYCLES - 1);

  cfcc_chan_if chif [`CFCC_NCH] ();
  for (genvar g = 0; g < `CFCC_NCH; g++) begin : g_ch
    assign chif[g].pulse_edge = pedge[g];
    assign chif[g].tick = tick;
    assign chif[g].stop_ovf = ovf_r[g] && up_ch[g];
    assign chif[g].load = load_r[g];
    assign chif[g].timeout = freq_ch[g] ? tmo_r : 8'h0;
    assign chif[g].preset = preset_r[g];
    assign cnt[g] = chif[g].count;
    assign fz[g] = chif[g].freq_zero;
    cfcc_chan u_chan (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .ch(chif[g])
    );
  end
  assign FREQ_ZERO = fz;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic [7:0] wr_addr_r, ha;
  logic [31:0] rd_r, rd_mux;
  assign ha = HADDR[7:0];

  always_comb begin
    rd_mux = '0;
    if ((ha & `CFCC_REGION) == `CFCC_OFS_COUNT) begin
      rd_mux = cnt[ha[4:2]];
    end else if ((ha & `CFCC_REGION) == `CFCC_OFS_PRESET) begin
      rd_mux = preset_r[ha[4:2]];
    end else begin
      unique case (ha)
        `CFCC_OFS_CTRL: rd_mux = {23'h0, chk_en_r, own_r};
        `CFCC_OFS_TYPE_LO: rd_mux = type_lo_r;
        `CFCC_OFS_TYPE_HI: rd_mux = type_hi_r;
        `CFCC_OFS_MODES: rd_mux = {tmo_r, ovf_r, high_r, auto_r};
        `CFCC_OFS_STATUS: rd_mux = {20'h0, state_r, fz};
        default: rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rd_r <= '0;
    end else if (HREADY) begin
      wr_pend_r <= HSEL && HTRANS[1] && HWRITE && HSIZE == `CFCC_HSIZE_WORD;
      wr_addr_r <= ha;
      if (HSEL && HTRANS[1] && !HWRITE) begin
        rd_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      own_r <= `CFCC_RST_ADDR;
      chk_en_r <= 1'b0;
      type_lo_r <= `CFCC_RST_TYPE;
      type_hi_r <= `CFCC_RST_TYPE;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        `CFCC_OFS_CTRL: begin
          own_r <= HWDATA[7:0];
          chk_en_r <= HWDATA[`CFCC_CTRL_CHK];
        end
        `CFCC_OFS_TYPE_LO: type_lo_r <= HWDATA;
        `CFCC_OFS_TYPE_HI: type_hi_r <= HWDATA;
        default: ;
      endcase
    end
  end

  assign HRDATA = rd_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
endmodule // cfcc_top
